/* hdl/iobf_pkg.sv */
package iobf_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RETRY = 8'h04;
   localparam logic [7:0] OFS_NONCRIT = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_CFG_STORED = 8'h18;
   localparam logic [7:0] OFS_CFG_ACTUAL = 8'h1C;
   localparam logic [7:0] OFS_CMD = 8'h20;
   // Field positions
   localparam int RETRY_CONT_BIT = 7;
   localparam int CTRL_CHECK_BIT = 0;
   localparam int CMD_KEEP_BIT = 0;
   localparam int CMD_ACCEPT_BIT = 1;
   localparam int CMD_STORE_BIT = 2;
   localparam int CMD_POWERUP_BIT = 3;
   localparam int CMD_INIT_BIT = 4;
   localparam int EV_PARITY = 0;
   localparam int EV_STOP = 1;
   localparam int EV_CFG_CHG = 2;
   localparam int EV_TOLERATED = 3;
   localparam int NUM_EV = 4;
   // Reset values
   localparam logic [7:0] RETRY_RESET = 8'h03;
   localparam logic [7:0] NONCRIT_RESET = 8'h00;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : iobf_pkg

/* hdl/iobf_xfer_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Transfer outcome reports from the scan to the fault policy engine
interface iobf_xfer_if;
   logic done;
   logic ok;
   logic [2:0] base_id;
   logic next_addr;
   logic halt;
   logic parity_err;
   logic tolerated;
   modport src (output done, output ok, output base_id,
      input next_addr, input halt, input parity_err, input tolerated);
   modport eng (input done, input ok, input base_id,
      output next_addr, output halt, output parity_err, output tolerated);
endinterface : iobf_xfer_if
`default_nettype wire

/* hdl/iobf_retry.sv */
`timescale 1ns/1ns
`default_nettype none
// Per-transfer retry counter and stop/continue/tolerate policy
module iobf_retry
   import iobf_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] retry_cfg,
   input wire logic [7:0] noncrit,
   iobf_xfer_if.eng xf
);
   logic [4:0] tries;
   logic [4:0] limit;
   wire fail = xf.done && !xf.ok;
   wire exhausted = fail && (tries >= limit);
   wire is_noncrit = noncrit[xf.base_id];
   wire cont_mode = retry_cfg[RETRY_CONT_BIT];
   // Limit is the retry count; total attempts = retries + 1
   assign limit = {1'b0, retry_cfg[3:0]};
   // R15: clear count on success or move on
   always_ff @(posedge clk)
   begin
      if (srst || (xf.done && xf.ok) || exhausted)
         tries <= 5'h00;
      else if (fail)
         tries <= tries + 5'h01;
   end
   // R2: parity error once retries spent
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         xf.parity_err <= 1'b0;
         xf.next_addr <= 1'b0;
         xf.halt <= 1'b0;
         xf.tolerated <= 1'b0;
      end
      else
      begin
         xf.parity_err <= exhausted;
         // R4: continue mode resumes at next address
         // R8: non-critical base never stops the run
         xf.next_addr <= exhausted && (cont_mode || is_noncrit);
         // R3: stop mode halts
         // R5: critical base fault halts in stop mode only
         xf.halt <= exhausted && !cont_mode && !is_noncrit;
         xf.tolerated <= exhausted && is_noncrit;
      end
   end
   a_halt_cause: assert property (@(posedge clk) disable iff (srst)
      xf.halt |-> $past(exhausted) && !$past(cont_mode)) // R3
      else $error("halt without exhausted retries in stop mode");
   a_cont_cause: assert property (@(posedge clk) disable iff (srst)
      $past(exhausted) && $past(cont_mode) |-> xf.next_addr && !xf.halt) // R4
      else $error("continue mode failed to resume");
   a_noncrit_run: assert property (@(posedge clk) disable iff (srst)
      $past(exhausted) && $past(is_noncrit) |-> !xf.halt) // R8
      else $error("non-critical base halted the run");
   a_tries_clear: assert property (@(posedge clk) disable iff (srst)
      xf.done && xf.ok |=> tries == 5'h00) // R15
      else $error("retry count not cleared after success");
endmodule : iobf_retry
`default_nettype wire

/* hdl/iobf_top.sv */
// Notes on behaviour
// R1: Retry count is 4-bit, 0..F, defaulting to three.
// R2: All attempts failing flags an I/O parity error.
// R3: Retry byte top bit clear: halt when retries run out.
// R4: Top bit set: keep running, continue scan at next address.
// R5: Fault in critical base: stop and record error. Code halts on it only in stop mode, not in continue mode.
// R6: Non-critical bitmap starts all clear; every base critical.
// R7: Bit n of 8-bit mask marks base n non-critical.
// R8: Faults on non-critical bases never stop the device.
// R9: Power-up check flags config change when actual differs.
// R10: Keep-stored command lets program run, maps unchanged.
// R11: Accept or store clears error, adopts actual, rewrites stored.
// R12: Write-protected cartridge: accepted config lasts to power cycle.
// R13: Load/store moves assignment map, type map and watchdog.
// R14: Full initialization enables power-up config checking.
// R15: Retry counter clears on success or moving to next address.
`timescale 1ns/1ns
`default_nettype none
module iobf_top
   import iobf_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // I/O bus transfer outcomes, from scan logic on clk
   input wire logic xfer_done,
   input wire logic xfer_ok,
   input wire logic [2:0] xfer_base_id,
   output logic scan_next_addr,
   output logic cpu_halt,
   output logic cfg_write_en,
   output logic irq
);
   import iobf_pkg::*;

   iobf_xfer_if xf ();

   logic [7:0] retry_cfg;
   logic [7:0] noncrit;
   logic check_en;
   logic cfg_chg_err;
   logic run_allowed;
   logic stopped;
   logic wprot;
   logic [31:0] cfg_stored;
   logic [31:0] cfg_actual;
   logic [31:0] cfg_working;
   logic [NUM_EV-1:0] irq_stat;
   logic [NUM_EV-1:0] irq_mask;
   logic [NUM_EV-1:0] ev;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_held;
   logic w_held;

   // Write channel decode; address and data may arrive in any order
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire [7:0] wa = aw_fire ? s_axi_awaddr : aw_addr;
   wire [31:0] wd = w_fire ? s_axi_wdata : w_data;
   wire [3:0] ws = w_fire ? s_axi_wstrb : w_strb;
   wire have_aw = aw_fire || aw_held;
   wire have_w = w_fire || w_held;
   wire wr_go = have_aw && have_w && !s_axi_bvalid;
   wire wr_b0 = wr_go && ws[0];
   wire wr_ctrl = wr_b0 && (wa == OFS_CTRL);
   wire wr_retry = wr_b0 && (wa == OFS_RETRY);
   wire wr_noncrit = wr_b0 && (wa == OFS_NONCRIT);
   wire wr_istat = wr_b0 && (wa == OFS_IRQ_STAT);
   wire wr_imask = wr_b0 && (wa == OFS_IRQ_MASK);
   wire wr_actual = wr_go && (ws == 4'hF) && (wa == OFS_CFG_ACTUAL);
   wire wr_cmd = wr_b0 && (wa == OFS_CMD);
   wire wr_known = (wa == OFS_CTRL) || (wa == OFS_RETRY) ||
      (wa == OFS_NONCRIT) || (wa == OFS_IRQ_STAT) ||
      (wa == OFS_IRQ_MASK) || (wa == OFS_CFG_ACTUAL) || (wa == OFS_CMD);
   wire cmd_keep = wr_cmd && wd[CMD_KEEP_BIT];
   wire cmd_accept = wr_cmd && (wd[CMD_ACCEPT_BIT] || wd[CMD_STORE_BIT]);
   wire cmd_powerup = wr_cmd && wd[CMD_POWERUP_BIT];
   wire cmd_init = wr_cmd && wd[CMD_INIT_BIT];
   wire cfg_differs = cfg_actual != cfg_stored;

   // Write handshake holding registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end
      else
      begin
         if (aw_fire)
            aw_addr <= s_axi_awaddr;
         if (w_fire)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         aw_held <= have_aw && !wr_go;
         w_held <= have_w && !wr_go;
      end
   end

   // Each ready only while its own channel has nothing parked and no response is pending, so each write is one beat
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !have_aw && !s_axi_bvalid && !aw_fire;
         s_axi_wready <= !have_w && !s_axi_bvalid && !w_fire;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // R1: retry setting, default three
   // R6: all bases critical from reset
   // R7: one bit per base identifier
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         retry_cfg <= RETRY_RESET;
         noncrit <= NONCRIT_RESET;
      end
      else
      begin
         if (wr_retry)
            retry_cfg <= {wd[RETRY_CONT_BIT], 3'h0, wd[3:0]};
         if (wr_noncrit)
            noncrit <= wd[7:0];
      end
   end

   // Retry engine
   assign xf.done = xfer_done;
   assign xf.ok = xfer_ok;
   assign xf.base_id = xfer_base_id;
   iobf_retry u_retry (
      .clk(clk),
      .srst(srst),
      .retry_cfg(retry_cfg),
      .noncrit(noncrit),
      .xf(xf)
   );

   // Configuration state; wprot from control reg bit 1
   // R9: power-up compare flags change
   // R10: keep-stored runs program, maps untouched
   // R11: accept adopts actual and rewrites
   // R12: protected cartridge keeps stored copy
   // R14: full init enables checking
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         check_en <= 1'b1;
         wprot <= 1'b0;
         cfg_chg_err <= 1'b0;
         run_allowed <= 1'b1;
         cfg_stored <= CFG_RESET;
         cfg_actual <= CFG_RESET;
         cfg_working <= CFG_RESET;
         cfg_write_en <= 1'b0;
      end
      else
      begin
         cfg_write_en <= 1'b0;
         if (wr_ctrl)
         begin
            check_en <= wd[CTRL_CHECK_BIT];
            wprot <= wd[1];
         end
         if (cmd_init)
            check_en <= 1'b1;
         if (wr_actual)
            cfg_actual <= wd;
         if (cmd_powerup)
         begin
            cfg_working <= cfg_stored;
            cfg_chg_err <= check_en && cfg_differs;
            run_allowed <= !(check_en && cfg_differs);
         end
         else if (cmd_accept)
         begin
            cfg_chg_err <= 1'b0;
            run_allowed <= 1'b1;
            cfg_working <= cfg_actual;
            if (!wprot)
            begin
               cfg_stored <= cfg_actual;
               // R13: store moves maps and watchdog
               cfg_write_en <= 1'b1;
            end
         end
         else if (cmd_keep)
         begin
            cfg_chg_err <= 1'b0;
            run_allowed <= 1'b1;
         end
      end
   end

   // Stopped state latches on halt until power-up; a halt wins a tie
   always_ff @(posedge clk)
   begin
      if (srst || (cmd_powerup && !xf.halt))
         stopped <= 1'b0;
      else if (xf.halt)
         stopped <= 1'b1;
   end

   // Events and sticky status; set wins over clear
   assign ev[EV_PARITY] = xf.parity_err;
   assign ev[EV_STOP] = xf.halt;
   assign ev[EV_CFG_CHG] = cmd_powerup && check_en && cfg_differs;
   assign ev[EV_TOLERATED] = xf.tolerated;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat <= (irq_stat & ~(wr_istat ? wd[NUM_EV-1:0] : '0)) | ev;
         if (wr_imask)
            irq_mask <= wd[NUM_EV-1:0];
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Outputs to scan and CPU from flops
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         scan_next_addr <= 1'b0;
         cpu_halt <= 1'b0;
      end
      else
      begin
         scan_next_addr <= xf.next_addr;
         cpu_halt <= stopped || xf.halt || !run_allowed;
      end
   end

   // Read channel
   wire rd_go = s_axi_arvalid && s_axi_arready;
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb
   begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         OFS_CTRL: rd_mux = {30'h0, wprot, check_en};
         OFS_RETRY: rd_mux = {24'h0, retry_cfg};
         OFS_NONCRIT: rd_mux = {24'h0, noncrit};
         OFS_STATUS: rd_mux = {28'h0, run_allowed, cfg_chg_err,
            stopped, xf.parity_err};
         OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat};
         OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask};
         OFS_CFG_STORED: rd_mux = cfg_stored;
         OFS_CFG_ACTUAL: rd_mux = cfg_working;
         default:
         begin
            rd_mux = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !rd_go;
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   a_cfg_flag: assert property (@(posedge clk) disable iff (srst)
      cmd_powerup && check_en && cfg_differs |=> cfg_chg_err) // R9
      else $error("config change not flagged at power-up");
   a_keep_maps: assert property (@(posedge clk) disable iff (srst)
      cmd_keep && !cmd_accept && !cmd_powerup |=> $stable(cfg_stored)) // R10
      else $error("keep command altered stored map");
   a_accept_adopt: assert property (@(posedge clk) disable iff (srst)
      cmd_accept && !cmd_powerup |=> !cfg_chg_err &&
      cfg_working == $past(cfg_actual)) // R11
      else $error("accept did not adopt actual config");
   a_wprot_keep: assert property (@(posedge clk) disable iff (srst)
      cmd_accept && wprot |=> $stable(cfg_stored) && !cfg_write_en) // R12
      else $error("protected cartridge was rewritten");
   a_init_check: assert property (@(posedge clk) disable iff (srst)
      cmd_init |=> check_en) // R14
      else $error("init did not enable config check");
   a_parity_irq: assert property (@(posedge clk) disable iff (srst)
      xf.parity_err |=> irq_stat[EV_PARITY]) // R2
      else $error("parity event not recorded");
   a_stop_state: assert property (@(posedge clk) disable iff (srst)
      xf.halt |=> stopped && cpu_halt) // R5
      else $error("halt did not reach stopped state");
   a_retry_dflt: assert property (@(posedge clk) disable iff (srst)
      $past(srst) |-> retry_cfg == RETRY_RESET && noncrit == 8'h00) // R1
      else $error("retry or mask reset value wrong");
endmodule : iobf_top
`default_nettype wire

/* sim/iobf_base_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Behavioural base unit: answers one scan attempt per request
module iobf_base_model
(
   input wire logic clk,
   input wire logic srst,
   input wire logic go,
   input wire logic want_ok,
   input wire logic [2:0] want_base,
   input wire logic slow,
   output logic xfer_done,
   output logic xfer_ok,
   output logic [2:0] xfer_base_id,
   output logic busy
);
   logic [1:0] cnt;
   logic last_ok;
   logic [2:0] last_base;
   // Released lines show the inverse of the last value, never a hold
   always_ff @(posedge clk)
   begin
      xfer_done <= 1'h0;
      xfer_ok <= ~last_ok;
      xfer_base_id <= ~last_base;
      if (srst)
      begin
         busy <= 1'h0;
         cnt <= 2'h0;
         last_ok <= 1'h0;
         last_base <= 3'h0;
      end
      else if (!busy && go)
      begin
         busy <= 1'h1;
         cnt <= slow ? 2'h3 : 2'h0;
         last_ok <= want_ok;
         last_base <= want_base;
      end
      else if (busy && cnt != 2'h0)
         cnt <= cnt - 2'h1;
      else if (busy)
      begin
         busy <= 1'h0;
         xfer_done <= 1'h1;
         xfer_ok <= last_ok;
         xfer_base_id <= last_base;
      end
   end
endmodule : iobf_base_model
`default_nettype wire

/* sim/tb_iobf_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_iobf_top;
   import iobf_pkg::*;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rr, wb;
   logic go = 1'h0, w_ok = 1'h0, slow = 1'h0;
   logic [2:0] w_base = 3'h0, bid;
   logic done, ok, busy, nxt, halt, cfgw, irq;
   int fails = 0, checks = 0, seed = 99, n_nxt = 0, n_cfgw = 0;
   int i, k, lim, cont, msk, cb, im, stop, tol, n0, c0;

   iobf_top uut (.clk(clk), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .xfer_done(done), .xfer_ok(ok),
      .xfer_base_id(bid), .scan_next_addr(nxt), .cpu_halt(halt),
      .cfg_write_en(cfgw), .irq(irq));
   iobf_base_model base (.clk(clk), .srst(srst), .go(go),
      .want_ok(w_ok), .want_base(w_base), .slow(slow),
      .xfer_done(done), .xfer_ok(ok), .xfer_base_id(bid),
      .busy(busy));

   // Clock, 100 ns period
   initial
   begin
      forever #50 clk = ~clk;
   end
   // Count one-cycle pulses so no check can miss them
   always @(posedge clk)
   begin
      n_nxt <= n_nxt + 32'(nxt);
      n_cfgw <= n_cfgw + 32'(cfgw);
   end

   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk

   // Write: address and data offered together, each released when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      k = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge clk);
         k++;
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!(bvalid && !awvalid && !wvalid) && k < 50);
      wb = bresp;
      bready <= 1'h0;
      if (k >= 50) fails++;
   endtask : wr

   task rdr(input logic [7:0] a);
      k = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge clk);
         k++;
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!(rvalid && !arvalid) && k < 50);
      rd = rdata;
      rr = rresp;
      rready <= 1'h0;
      if (k >= 50) fails++;
   endtask : rdr

   // One scan attempt through the base model, prompt or slow
   task att(input logic o);
      go <= 1'h1;
      w_ok <= o;
      w_base <= 3'(cb);
      slow <= 1'($random(seed));
      @(posedge clk);
      go <= 1'h0;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (busy && k < 20);
   endtask : att

   task wrap_up;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   // Hang guard, far beyond the expected run
   initial
   begin
      repeat (30000) @(posedge clk);
      fails++;
      wrap_up;
   end

   initial
   begin
      repeat (8) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      rdr(OFS_RETRY); chk(rd, 32'h3);
      rdr(OFS_NONCRIT); chk(rd, 32'h0);
      rdr(OFS_CTRL); chk(rd & 32'h1, 32'h1);
      rdr(8'h40); chk(32'(rr), 32'(RESP_SLVERR));
      chk(rd, 32'h0);
      wr(8'h40, 32'h0); chk(32'(wb), 32'(RESP_SLVERR));
      $display("reset test done");
      // Retry policy sweep; a success midway must restart the count
      for (i = 0; i < 6; i++)
      begin
         lim = (i == 0) ? 0 : (i == 1) ? 15 : $random(seed) & 15;
         cont = $random(seed) & 1;
         msk = (i == 0) ? 0 : $random(seed) & 255;
         cb = $random(seed) & 7;
         im = i & 1;
         tol = (msk >> cb) & 1;
         stop = (tol == 0 && cont == 0) ? 1 : 0;
         wr(OFS_RETRY, cont * 128 + lim);
         wr(OFS_NONCRIT, msk);
         wr(OFS_IRQ_MASK, im);
         n0 = n_nxt;
         repeat (lim) att(1'h0);
         att(1'h1);
         repeat (lim) att(1'h0);
         repeat (4) @(posedge clk);
         chk(n_nxt - n0, 32'h0);
         chk(32'(halt), 32'h0);
         att(1'h0);
         repeat (4) @(posedge clk);
         chk(32'(halt), stop);
         chk(n_nxt - n0, 1 - stop);
         rdr(OFS_IRQ_STAT); chk(rd, 1 + 2 * stop + 8 * tol);
         chk(32'(irq), im);
         wr(OFS_IRQ_STAT, 32'hF);
         wr(OFS_CMD, 32'h8);
         repeat (3) @(posedge clk);
         chk(32'(irq), 32'h0);
         $display("retry case %0d done", i);
      end
      // Stored versus actual configuration
      wr(OFS_CFG_ACTUAL, 32'h1234_5678);
      wr(OFS_CMD, 32'h8);
      repeat (3) @(posedge clk);
      chk(32'(halt), 32'h1);
      wr(OFS_CMD, 32'h1);
      repeat (3) @(posedge clk);
      chk(32'(halt), 32'h0);
      rdr(OFS_CFG_STORED); chk(rd, 32'h0);
      c0 = n_cfgw;
      wr(OFS_CMD, 32'h2);
      repeat (3) @(posedge clk);
      rdr(OFS_CFG_STORED); chk(rd, 32'h1234_5678);
      chk(n_cfgw - c0, 32'h1);
      rdr(OFS_STATUS); chk(rd & 32'h4, 32'h0);
      // Write-protected cartridge keeps its setup
      wr(OFS_CTRL, 32'h3);
      wr(OFS_CFG_ACTUAL, 32'hA5);
      wr(OFS_CMD, 32'h4);
      repeat (3) @(posedge clk);
      chk(n_cfgw - c0, 32'h1);
      rdr(OFS_CFG_STORED); chk(rd, 32'h1234_5678);
      rdr(OFS_CFG_ACTUAL); chk(rd, 32'hA5);
      wr(OFS_CMD, 32'h8);
      repeat (3) @(posedge clk);
      rdr(OFS_CFG_ACTUAL); chk(rd, 32'h1234_5678);
      chk(32'(halt), 32'h1);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CMD, 32'h10);
      rdr(OFS_CTRL); chk(rd & 32'h1, 32'h1);
      wr(OFS_RETRY, 32'h8F);
      chk(32'(wb), 32'(RESP_OKAY));
      rdr(OFS_RETRY); chk(rd, 32'h8F);
      $display("config test done");
      wrap_up;
   end
endmodule : tb_iobf_top
`default_nettype wire
